// File: hdl/rtc_consts.svh
// Constants of the real-time clock block: register map, field positions, reset values, timing.
// Behaviour
// - Day load strobe copies trigger low 14 bits
// - Time load strobe copies trigger halves, self-clears
// - Mode bit 5 enables match mode
// - Mode bit 4 enables periodic mode
// - Bit 3 drops LSB from match compare
// - Period select codes 0.125 to 16 s
// - Match compares two-second and tick halves
// - Read-only 16-bit tick count at 32768 Hz
// - Read-only 16-bit count in two-second units
// - Day count in bits 13:0, rest zero
// - Elapsed period sets sticky period flag, interrupt
// - Counter match sets sticky match flag, interrupt
// - Source switch finishes within the 16000 ns wait bound
// - Clear bits read 1 when mode disabled
// - Flags at bits 7 and 6, read-only
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

`define RTC_OFS_MODE     8'h00
`define RTC_OFS_FLAG     8'h04
`define RTC_OFS_TRIG     8'h08
`define RTC_OFS_TICK     8'h0C
`define RTC_OFS_TWOS     8'h10
`define RTC_OFS_DAY      8'h14
`define RTC_OFS_CKCFG    8'h18

`define RTC_MODE_RESET   8'hC2
`define RTC_TRIG_RESET   32'h0000_0000
`define RTC_CKCFG_RESET  8'h12

`define RTC_FLAG_MATCH   7
`define RTC_FLAG_PERIOD  6
`define RTC_CLR_MATCH    5
`define RTC_CLR_PERIOD   4

`define RTC_CK_XT_PON    0
`define RTC_CK_INT_PON   1
`define RTC_CK_SRC_SEL   2
`define RTC_CK_SRC_ACT   3
`define RTC_CK_BIAS_LO   4
`define RTC_CK_BIAS_HI   5

`define RTC_PERIOD_SHIFT 12
`define RTC_DAY_WIDTH    14
`define RTC_TWOS_PER_DAY 16'hA8C0
`define RTC_SWITCH_NS    16000
`define RTC_SYS_NS       50

`endif

// File: hdl/rtc_pkg.sv
// Types shared by the real-time clock modules.
package rtc_pkg;

   typedef struct packed {
      logic       day_load;
      logic       time_load;
      logic       match_en;
      logic       period_en;
      logic       lsb_ignore;
      logic [2:0] period_sel;
   } rtc_mode_t;

   typedef struct packed {
      logic [15:0] two_sec;
      logic [15:0] tick;
   } rtc_time_t;

   typedef enum logic [2:0] {
      SRC_INT  = 3'b001,
      SRC_WAIT = 3'b010,
      SRC_XT   = 3'b100
   } rtc_src_state_t;

endpackage

// File: hdl/rtc_clk_src.sv
// Low-speed clock source selection and tick generation.
`include "rtc_consts.svh"
module rtc_clk_src #(
   parameter int SWITCH_CYC = `RTC_SWITCH_NS / `RTC_SYS_NS
) (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst,
   // Oscillator levels.
   input  wire logic int_clk,
   input  wire logic xt_clk,
   // Selection request and results.
   input  wire logic xt_req,
   output logic      tick,
   output logic      xt_active
);
   import rtc_pkg::*;

   rtc_src_state_t state_reg;
   logic [15:0]    wait_reg;
   logic           lvl_d_reg;
   logic           src_is_xt;
   logic           lvl;
   logic           switch_ok;

   assign src_is_xt = (state_reg == SRC_XT) || ((state_reg == SRC_WAIT) && !xt_req);
   assign lvl       = src_is_xt ? xt_clk : int_clk;
   // Switching while both levels are low avoids a short pulse; the wait bound forces it.
   assign switch_ok = (!int_clk && !xt_clk) || (wait_reg >= 16'(SWITCH_CYC - 1));

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= SRC_INT;
      end else begin
         case (state_reg)
            SRC_INT: begin
               if (xt_req) state_reg <= SRC_WAIT;
            end
            SRC_XT: begin
               if (!xt_req) state_reg <= SRC_WAIT;
            end
            SRC_WAIT: begin
               if (switch_ok) state_reg <= xt_req ? SRC_XT : SRC_INT;
            end
            default: state_reg <= SRC_INT;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst || state_reg != SRC_WAIT) wait_reg <= 16'h0000;
      else wait_reg <= wait_reg + 16'h0001;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lvl_d_reg <= 1'b0;
         tick      <= 1'b0;
         xt_active <= 1'b0;
      end else begin
         lvl_d_reg <= lvl;
         tick      <= lvl && !lvl_d_reg;
         xt_active <= (state_reg == SRC_XT);
      end
   end
endmodule

// File: hdl/rtc_counter.sv
// Cascaded tick, two-second and day counters with software preset.
`include "rtc_consts.svh"
module rtc_counter #(
   parameter int          DAY_W    = `RTC_DAY_WIDTH,
   parameter logic [15:0] TWOS_DAY = `RTC_TWOS_PER_DAY
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             rst,
   // Advance and preset.
   input  wire logic             tick,
   input  wire logic             load_day,
   input  wire logic             load_time,
   input  wire rtc_pkg::rtc_time_t load_val,
   // Counter state.
   output rtc_pkg::rtc_time_t    now,
   output logic [DAY_W-1:0]      day,
   output logic                  upd
);
   import rtc_pkg::*;

   logic tick_wrap;
   logic twos_wrap;

   assign tick_wrap = (now.tick == 16'hFFFF);
   assign twos_wrap = (now.two_sec == TWOS_DAY - 16'h0001);

   always_ff @(posedge clk) begin
      if (rst) begin
         now <= '0;
      end else if (load_time) begin
         now <= load_val;
      end else if (tick) begin
         now.tick <= now.tick + 16'h0001;
         if (tick_wrap) now.two_sec <= twos_wrap ? 16'h0000 : now.two_sec + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) day <= '0;
      else if (load_day) day <= load_val[DAY_W-1:0];
      else if (tick && !load_time && tick_wrap && twos_wrap) day <= day + 1'b1;
   end

   always_ff @(posedge clk) begin
      if (rst) upd <= 1'b0;
      else upd <= tick && !load_time;
   end
endmodule

// File: hdl/rtc_timer.sv
// Real-time clock top: register file, periodic and match events, clock configuration.
`include "rtc_consts.svh"
module rtc_timer #(
   parameter int ADDR_W = 8,
   parameter int DAY_W  = `RTC_DAY_WIDTH
) (
   // System clock and reset.
   input  wire logic              CLK_SYS,
   input  wire logic              RST,
   // Register port.
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [31:0]       WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic [31:0]            RDATA,
   // Low-speed oscillator levels.
   input  wire logic              INT_OSC_CLK,
   input  wire logic              XTAL_CLK,
   // Oscillator control.
   output logic                   XTAL_PON,
   output logic                   INTOSC_PON,
   output logic [1:0]             XTAL_BIAS,
   output logic                   XTAL_ACTIVE,
   // Event requests.
   output logic                   MATCH_IRQ,
   output logic                   PERIOD_IRQ
);
   import rtc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   function automatic logic period_hit(rtc_time_t t, logic [2:0] sel);
      logic [31:0] mask;
      mask = (32'h0000_0001 << (5'(`RTC_PERIOD_SHIFT) + 5'(sel))) - 32'h0000_0001;
      return ((t & mask) == 32'h0000_0000);
   endfunction

   function automatic logic time_match(rtc_time_t t, logic [31:0] trig, logic ign);
      logic [31:0] mask;
      mask = ign ? 32'hFFFF_FFFE : 32'hFFFF_FFFF;
      return ((t & mask) == (trig & mask));
   endfunction

   function automatic logic addr_is(logic [ADDR_W-1:0] a, logic [7:0] ofs);
      return (a == ADDR_W'(ofs));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Register state.

   rtc_mode_t   mode_reg;
   logic [31:0] trig_reg;
   logic        match_flag_reg;
   logic        period_flag_reg;
   logic        match_clr_reg;
   logic        period_clr_reg;
   logic        xt_pon_reg;
   logic        int_pon_reg;
   logic        src_sel_reg;
   logic [1:0]  bias_reg;

   logic        wr_mode;
   logic        wr_flag;
   logic        wr_trig;
   logic        wr_ckcfg;

   assign wr_mode  = WR && addr_is(ADDR, `RTC_OFS_MODE);
   assign wr_flag  = WR && addr_is(ADDR, `RTC_OFS_FLAG);
   assign wr_trig  = WR && addr_is(ADDR, `RTC_OFS_TRIG);
   assign wr_ckcfg = WR && addr_is(ADDR, `RTC_OFS_CKCFG);

   ////////////////////////////////////////////////////////////////////////////////
   // Counters and clock source.

   rtc_time_t        now;
   logic [DAY_W-1:0] day;
   logic             upd;
   logic             tick;
   logic             xt_active;

   rtc_clk_src u_src (
      .clk       (CLK_SYS),
      .rst       (RST),
      .int_clk   (INT_OSC_CLK),
      .xt_clk    (XTAL_CLK),
      .xt_req    (src_sel_reg),
      .tick      (tick),
      .xt_active (xt_active)
   );

   rtc_counter #(
      .DAY_W (DAY_W)
   ) u_cnt (
      .clk       (CLK_SYS),
      .rst       (RST),
      .tick      (tick),
      .load_day  (mode_reg.day_load),
      .load_time (mode_reg.time_load),
      .load_val  (rtc_time_t'(trig_reg)),
      .now       (now),
      .day       (day),
      .upd       (upd)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Mode control.

   // The load strobes act in the cycle after they are written and then drop by themselves.
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         mode_reg <= rtc_mode_t'(`RTC_MODE_RESET);
      end else if (wr_mode) begin
         mode_reg <= rtc_mode_t'(WDATA[7:0]);
      end else begin
         mode_reg.day_load  <= 1'b0;
         mode_reg.time_load <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         trig_reg <= `RTC_TRIG_RESET;
      end else if (wr_trig) begin
         trig_reg <= WDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event detection.

   logic period_evt;
   logic match_evt;

   assign period_evt = upd && mode_reg.period_en && period_hit(now, mode_reg.period_sel);
   assign match_evt  = upd && mode_reg.match_en
                       && time_match(now, trig_reg, mode_reg.lsb_ignore);

   ////////////////////////////////////////////////////////////////////////////////
   // Flags and clear bits.

   logic match_clr_hit;
   logic period_clr_hit;

   assign match_clr_hit  = wr_flag && WDATA[`RTC_CLR_MATCH] && mode_reg.match_en;
   assign period_clr_hit = wr_flag && WDATA[`RTC_CLR_PERIOD] && mode_reg.period_en;

   // A new event in the clearing cycle keeps the flag set.
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         match_flag_reg <= 1'b0;
      end else begin
         match_flag_reg <= match_evt || (match_flag_reg && !match_clr_hit);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         period_flag_reg <= 1'b0;
      end else begin
         period_flag_reg <= period_evt || (period_flag_reg && !period_clr_hit);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         match_clr_reg <= 1'b0;
      end else begin
         match_clr_reg <= match_clr_hit;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         period_clr_reg <= 1'b0;
      end else begin
         period_clr_reg <= period_clr_hit;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         MATCH_IRQ <= 1'b0;
      end else begin
         MATCH_IRQ <= match_flag_reg;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         PERIOD_IRQ <= 1'b0;
      end else begin
         PERIOD_IRQ <= period_flag_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Low-speed clock configuration.

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         xt_pon_reg <= 1'(`RTC_CKCFG_RESET >> `RTC_CK_XT_PON);
      end else if (wr_ckcfg) begin
         xt_pon_reg <= WDATA[`RTC_CK_XT_PON];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         int_pon_reg <= 1'(`RTC_CKCFG_RESET >> `RTC_CK_INT_PON);
      end else if (wr_ckcfg) begin
         int_pon_reg <= WDATA[`RTC_CK_INT_PON];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         src_sel_reg <= 1'(`RTC_CKCFG_RESET >> `RTC_CK_SRC_SEL);
      end else if (wr_ckcfg) begin
         src_sel_reg <= WDATA[`RTC_CK_SRC_SEL];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         bias_reg <= 2'(`RTC_CKCFG_RESET >> `RTC_CK_BIAS_LO);
      end else if (wr_ckcfg) begin
         bias_reg <= WDATA[`RTC_CK_BIAS_HI:`RTC_CK_BIAS_LO];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         XTAL_PON <= 1'b0;
      end else begin
         XTAL_PON <= xt_pon_reg;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         INTOSC_PON <= 1'b0;
      end else begin
         INTOSC_PON <= int_pon_reg;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         XTAL_BIAS <= 2'h0;
      end else begin
         XTAL_BIAS <= bias_reg;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         XTAL_ACTIVE <= 1'b0;
      end else begin
         XTAL_ACTIVE <= xt_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read port.

   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h0000_0000;
      if (addr_is(ADDR, `RTC_OFS_MODE)) begin
         rd_word[7:0] = mode_reg;
      end else if (addr_is(ADDR, `RTC_OFS_FLAG)) begin
         rd_word[`RTC_FLAG_MATCH]  = match_flag_reg;
         rd_word[`RTC_FLAG_PERIOD] = period_flag_reg;
         rd_word[`RTC_CLR_MATCH]   = !mode_reg.match_en || match_clr_reg;
         rd_word[`RTC_CLR_PERIOD]  = !mode_reg.period_en || period_clr_reg;
      end else if (addr_is(ADDR, `RTC_OFS_TRIG)) begin
         rd_word = trig_reg;
      end else if (addr_is(ADDR, `RTC_OFS_TICK)) begin
         rd_word[15:0] = now.tick;
      end else if (addr_is(ADDR, `RTC_OFS_TWOS)) begin
         rd_word[15:0] = now.two_sec;
      end else if (addr_is(ADDR, `RTC_OFS_DAY)) begin
         rd_word[DAY_W-1:0] = day;
      end else if (addr_is(ADDR, `RTC_OFS_CKCFG)) begin
         rd_word[`RTC_CK_XT_PON]  = xt_pon_reg;
         rd_word[`RTC_CK_INT_PON] = int_pon_reg;
         rd_word[`RTC_CK_SRC_SEL] = src_sel_reg;
         rd_word[`RTC_CK_SRC_ACT] = xt_active;
         rd_word[`RTC_CK_BIAS_HI:`RTC_CK_BIAS_LO] = bias_reg;
      end
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         RDATA <= 32'h0000_0000;
      end else if (RD) begin
         RDATA <= rd_word;
      end else begin
         RDATA <= 32'h0000_0000;
      end
   end
endmodule

// File: sim/rtc_timer_assertions.sv
// Port-level checker of the real-time clock block, bound to its top module.
`include "rtc_consts.svh"
module rtc_timer_checker #(
   parameter int ADDR_W = 8
) (
   // System clock and reset.
   input wire logic              CLK_SYS,
   input wire logic              RST,
   // Register port.
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [31:0]       WDATA,
   input wire logic              WR,
   input wire logic              RD,
   input wire logic [31:0]       RDATA,
   // Oscillator control and events.
   input wire logic              XTAL_PON,
   input wire logic              INTOSC_PON,
   input wire logic [1:0]        XTAL_BIAS,
   input wire logic              XTAL_ACTIVE,
   input wire logic              MATCH_IRQ,
   input wire logic              PERIOD_IRQ
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);

   logic m_clr;
   logic p_clr;
   logic ck_wr;
   assign m_clr = WR && ADDR == `RTC_OFS_FLAG && WDATA[`RTC_CLR_MATCH];
   assign p_clr = WR && ADDR == `RTC_OFS_FLAG && WDATA[`RTC_CLR_PERIOD];
   assign ck_wr = WR && ADDR == `RTC_OFS_CKCFG;

   a_mode_width: assert property (RD && ADDR == `RTC_OFS_MODE |=>
      RDATA[31:8] == 24'h00_0000) else $error("mode read has upper bits set");
   a_day_reserved: assert property (RD && ADDR == `RTC_OFS_DAY |=>
      RDATA[31:14] == 18'h0_0000) else $error("day read has reserved bits set");
   a_count_width: assert property (RD && (ADDR == `RTC_OFS_TICK ||
      ADDR == `RTC_OFS_TWOS) |=> RDATA[31:16] == 16'h0000)
      else $error("counter read has upper bits set");
   a_match_flag_irq: assert property (RD && ADDR == `RTC_OFS_FLAG |=>
      RDATA[`RTC_FLAG_MATCH] == MATCH_IRQ && RDATA[3:0] == 4'h0)
      else $error("match flag read differs from match request");
   a_period_flag_irq: assert property (RD && ADDR == `RTC_OFS_FLAG |=>
      RDATA[`RTC_FLAG_PERIOD] == PERIOD_IRQ) else $error("period flag read differs from request");
   a_match_sticky: assert property (MATCH_IRQ && !m_clr && !$past(m_clr) |=> MATCH_IRQ)
      else $error("match request dropped without a clear");
   a_period_sticky: assert property (PERIOD_IRQ && !p_clr && !$past(p_clr)
      |=> PERIOD_IRQ) else $error("period request dropped without a clear");
   a_power_copy: assert property (ck_wr |-> ##2 XTAL_PON == $past(WDATA[0], 2) &&
      INTOSC_PON == $past(WDATA[1], 2)) else $error("oscillator power does not follow write");
   a_bias_copy: assert property (ck_wr |-> ##2 XTAL_BIAS == $past(WDATA[5:4], 2))
      else $error("crystal bias does not follow write");
   a_xtal_switch: assert property (ck_wr && WDATA[`RTC_CK_SRC_SEL]
      |-> ##[1:330] XTAL_ACTIVE) else $error("crystal source switch did not finish in time");
endmodule

bind rtc_timer rtc_timer_checker #(.ADDR_W(ADDR_W)) chk_u (
   .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .XTAL_PON(XTAL_PON), .INTOSC_PON(INTOSC_PON), .XTAL_BIAS(XTAL_BIAS),
   .XTAL_ACTIVE(XTAL_ACTIVE), .MATCH_IRQ(MATCH_IRQ), .PERIOD_IRQ(PERIOD_IRQ));

// File: sim/rtc_timing_trigger_counter_tb_top.sv
// Register-level testbench of the real-time clock block.
module rtc_timing_trigger_counter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, rst, wr_s, rd_s, osc, x_pon, i_pon, x_act, m_irq, p_irq;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [1:0]  x_bias;
   int          failures, samples_checked;

   // Both oscillator levels follow one wave, so the tick keeps coming after the switch.
   rtc_timer dut_u (
      .CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
      .RDATA(rdata), .INT_OSC_CLK(osc), .XTAL_CLK(osc), .XTAL_PON(x_pon),
      .INTOSC_PON(i_pon), .XTAL_BIAS(x_bias), .XTAL_ACTIVE(x_act),
      .MATCH_IRQ(m_irq), .PERIOD_IRQ(p_irq));

   task automatic conclude();
      if (failures == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'h1;
      @(posedge clk);
      wr_s <= 1'h0;
   endtask

   task automatic ck(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'h1;
      @(posedge clk);
      rd_s <= 1'h0;
      #1;
      cmp($sformatf("reg %h", a), e, rdata);
   endtask

   // One oscillator period; leaves time for tick, counter, flag and request to settle.
   task automatic tk();
      @(posedge clk);
      osc <= 1'h1;
      repeat (3) @(posedge clk);
      osc <= 1'h0;
      repeat (6) @(posedge clk);
   endtask

   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      conclude();
   end

   initial begin
      logic [31:0] v;
      {rst, wr_s, rd_s, osc} = 4'h8;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      repeat (3) @(posedge clk);
      ck(8'h00, 32'h0000_0002);
      ck(8'h04, 32'h0000_0030);
      cmp("irq", 32'h0000_0000, {30'h0, m_irq, p_irq});
      ck(8'h08, 32'h0000_0000);
      ck(8'h18, 32'h0000_0012);
      cmp("osc outputs", 32'h0000_0005, {27'h0, x_act, x_pon, i_pon, x_bias});
      ck(8'h1C, 32'h0000_0000);
      ck(8'h0C, 32'h0000_0000);
      wr(8'h08, 32'hFFFF_FFFE);
      wr(8'h00, 32'h0000_0080);
      ck(8'h14, 32'h0000_3FFE);
      ck(8'h00, 32'h0000_0000);
      wr(8'h08, 32'hA8BF_FFFF);
      wr(8'h00, 32'h0000_0040);
      ck(8'h0C, 32'h0000_FFFF);
      ck(8'h10, 32'h0000_A8BF);
      ck(8'h00, 32'h0000_0000);
      wr(8'h0C, 32'h0000_0000);
      wr(8'h10, 32'h0000_0000);
      ck(8'h0C, 32'h0000_FFFF);
      ck(8'h10, 32'h0000_A8BF);
      tk();
      ck(8'h0C, 32'h0000_0000);
      ck(8'h10, 32'h0000_0000);
      ck(8'h14, 32'h0000_3FFF);
      for (int s = 0; s < 8; s++) begin
         v = (32'h0000_0001 << (12 + s)) - 32'h0000_0002;
         wr(8'h08, v);
         wr(8'h00, 32'h0000_0050 | {29'h0, 3'(s)});
         tk();
         ck(8'h04, 32'h0000_0020);
         tk();
         ck(8'h04, 32'h0000_0060);
         cmp("period irq", 32'h0000_0001, {31'h0, p_irq});
         wr(8'h04, 32'h0000_0010);
         ck(8'h04, 32'h0000_0020);
         cmp("period irq", 32'h0000_0000, {31'h0, p_irq});
      end
      wr(8'h08, 32'h0001_0001);
      wr(8'h00, 32'h0000_0060);
      // The match point is the loaded time plus a short delay in ticks.
      wr(8'h08, 32'h0001_0003);
      tk();
      ck(8'h04, 32'h0000_0010);
      tk();
      ck(8'h04, 32'h0000_0090);
      cmp("match irq", 32'h0000_0001, {31'h0, m_irq});
      tk();
      ck(8'h04, 32'h0000_0090);
      wr(8'h00, 32'h0000_0000);
      wr(8'h04, 32'h0000_0020);
      ck(8'h04, 32'h0000_00B0);
      wr(8'h00, 32'h0000_0028);
      wr(8'h04, 32'h0000_0020);
      ck(8'h04, 32'h0000_0010);
      wr(8'h08, 32'h0001_0007);
      tk();
      ck(8'h04, 32'h0000_0010);
      tk();
      ck(8'h04, 32'h0000_0090);
      // A high level during the switch makes the source wait for its time bound.
      @(posedge clk);
      osc <= 1'h1;
      wr(8'h18, 32'h0000_0033);
      wr(8'h18, 32'h0000_0037);
      repeat (340) @(posedge clk);
      osc <= 1'h0;
      ck(8'h18, 32'h0000_003F);
      cmp("osc outputs", 32'h0000_001F, {27'h0, x_act, x_pon, i_pon, x_bias});
      wr(8'h18, 32'h0000_0017);
      ck(8'h18, 32'h0000_001F);
      cmp("osc outputs", 32'h0000_001D, {27'h0, x_act, x_pon, i_pon, x_bias});
      tk();
      ck(8'h0C, 32'h0000_0008);
      conclude();
   end
endmodule
